// [inc/fastlock_pkg.sv]
// Shared constants and state layouts for the RF fastlock time-out controller.
`default_nettype none
package fastlock_pkg;
  localparam int ADDR_W = 4;
  localparam int WORD_W = 24;
  localparam int TOC_W = 12;
  localparam int TOC_LSB = 3;
  localparam int TOC_MSB = 14;
  localparam int WORD_BYTES = 3;

  localparam logic [ADDR_W-1:0] TIMEOUT_WORD_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] PUMP_CONTROL_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;

  localparam int PUMP_GAIN_BIT = 0;
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_AUTO_BIT = 12;
  localparam int STATUS_PEND_BIT = 13;
  localparam int STATUS_OE_BIT = 14;
  localparam int STATUS_LEVEL_BIT = 15;
  localparam int STATUS_PUMP_BIT = 16;
  localparam int STATUS_GAIN_BIT = 17;
  localparam int STATUS_CODE_LSB = 18;

  localparam logic [WORD_W-1:0] TIMEOUT_WORD_RESET = 24'h000002;
  localparam logic [TOC_W-1:0] CODE_TRISTATE = 12'h000;
  localparam logic [TOC_W-1:0] CODE_MANUAL = 12'h001;
  localparam logic [TOC_W-1:0] CODE_DRIVE_LOW = 12'h002;
  localparam logic [TOC_W-1:0] CODE_DRIVE_HIGH = 12'h003;
  localparam logic [TOC_W-1:0] AUTO_MIN_CODE = 12'h004;
  localparam logic [TOC_W-1:0] COUNT_STEP = 12'h001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] stages;
    logic level;
    logic pulse;
  } sync_state_s;

  typedef struct packed {
    logic awready;
    logic awHave;
    logic [ADDR_W-1:0] awAddr;
    logic wready;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [WORD_W-1:0] pendWord;
    logic pendValid;
    logic [TOC_W-1:0] fastlockTimeoutCode;
    logic [TOC_W-1:0] eventCount;
    logic autoActive;
    logic rfPumpGainSelect;
    logic pinOut;
    logic pinOe;
    logic pumpHigh;
  } ctrl_state_s;

  localparam ctrl_state_s CTRL_STATE_RESET = '{pendWord: TIMEOUT_WORD_RESET, default: '0};
endpackage : fastlock_pkg
`default_nettype wire

// [core/pfd_event_sync.sv]
// Three-stage synchroniser and rising-edge pulse for the phase-detector event pin.
`timescale 1ns/10ps
`default_nettype none
module pfd_event_sync
  import fastlock_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic pinLevel,
  output logic eventPulse
);
  sync_state_s q;
  sync_state_s d;
  logic stable;

  always_comb begin
    d = q;
    // The first stage feeds only the second, so metastability never reaches the filter.
    d.stages = {q.stages[1:0], pinLevel};
    stable = (q.stages[1] == q.stages[2]);
    d.level = stable ? q.stages[1] : q.level;
    d.pulse = stable && q.stages[1] && !q.level;
    if (!resetn) begin
      d = '0;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign eventPulse = q.pulse;
endmodule : pfd_event_sync
`default_nettype wire

// [core/rf_fastlock_timeout_control.sv]
// RF fastlock time-out controller with an AXI4-Lite register slave.
// Overview of operation
// [RQ1] Codes 0 to 3 keep automatic fastlock off; pin is general output or manual.
// [RQ2] Code 0: pin high impedance, pump current follows the pump gain bit.
// [RQ3] Code 1: pin driven low, pump forced to 4 mA, manual fastlock.
// [RQ4] Code 2: pin driven low, pump current follows the pump gain bit.
// [RQ5] Code 3: pin driven high, pump current follows the pump gain bit.
// [RQ6] Codes 4 to 4095 start automatic fastlock: pin low, pump at 4 mA.
// [RQ7] Count events; at the programmed count release pin and drop pump to 1 mA.
// [RQ8] A written code is latched and acted on only at the next event.
// [RQ9] Host places the code in bits 14 down to 3 of the control word.
// [RQ10] The code is a 12-bit unsigned value from 0 to 4095.
// [RQ11] Each latched code of 4 or more restarts the count and reasserts fastlock.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rf_fastlock_timeout_control
  import fastlock_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic pfdEventPin,
  output logic fastlockIndicatorPinOut,
  output logic fastlockIndicatorPinOe,
  output logic rfPumpOutputCurrentHigh
);
  ctrl_state_s q;
  ctrl_state_s d;
  logic pfdEvent;
  logic [TOC_W-1:0] pendCode;
  logic [31:0] statusWord;

  function automatic logic [WORD_W-1:0] mergeBytes(input logic [WORD_W-1:0] old,
                                                   input logic [31:0] data,
                                                   input logic [3:0] strb);
    logic [WORD_W-1:0] r;
    r = old;
    for (int i = 0; i < WORD_BYTES; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  pfd_event_sync eventSync (
    .clock(clock),
    .resetn(resetn),
    .pinLevel(pfdEventPin),
    .eventPulse(pfdEvent)
  );

  assign pendCode = q.pendWord[TOC_MSB:TOC_LSB]; // see [RQ9]

  always_comb begin
    statusWord = '0;
    statusWord[STATUS_COUNT_LSB +: TOC_W] = q.eventCount;
    statusWord[STATUS_AUTO_BIT] = q.autoActive;
    statusWord[STATUS_PEND_BIT] = q.pendValid;
    statusWord[STATUS_OE_BIT] = q.pinOe;
    statusWord[STATUS_LEVEL_BIT] = q.pinOut;
    statusWord[STATUS_PUMP_BIT] = q.pumpHigh;
    statusWord[STATUS_GAIN_BIT] = q.rfPumpGainSelect;
    statusWord[STATUS_CODE_LSB +: TOC_W] = q.fastlockTimeoutCode;
  end

  always_comb begin
    d = q;
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (awvalid && q.awready) begin
      d.awHave = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.wHave = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end
    // The event acts on the word pending before this cycle's write, which stays pending.
    if (pfdEvent) begin
      if (q.pendValid) begin
        d.pendValid = 1'b0;
        d.fastlockTimeoutCode = pendCode; // see [RQ8] see [RQ10]
        d.eventCount = '0; // see [RQ11]
        d.autoActive = (pendCode >= AUTO_MIN_CODE); // see [RQ1] see [RQ6] see [RQ11]
      end else if (q.autoActive) begin
        d.eventCount = q.eventCount + COUNT_STEP; // see [RQ7]
        if (d.eventCount == q.fastlockTimeoutCode) begin
          d.autoActive = 1'b0; // see [RQ7]
        end
      end
    end
    if (d.awHave && d.wHave && !d.bvalid) begin
      d.awHave = 1'b0;
      d.wHave = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (d.awAddr)
        TIMEOUT_WORD_OFFSET: begin
          d.pendWord = mergeBytes(q.pendWord, d.wData, d.wStrb);
          d.pendValid = 1'b1; // see [RQ8]
        end
        PUMP_CONTROL_OFFSET: begin
          if (d.wStrb[0]) begin
            d.rfPumpGainSelect = d.wData[PUMP_GAIN_BIT];
          end
        end
        STATUS_OFFSET: begin
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      case (araddr)
        TIMEOUT_WORD_OFFSET: d.rdata[WORD_W-1:0] = q.pendWord;
        PUMP_CONTROL_OFFSET: d.rdata[PUMP_GAIN_BIT] = q.rfPumpGainSelect;
        STATUS_OFFSET: d.rdata = statusWord;
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    d.awready = !d.awHave && !d.bvalid;
    d.wready = !d.wHave && !d.bvalid;
    d.arready = !d.rvalid;
    // Pin and pump follow the next code so that outputs never lag the latched state.
    d.pinOe = 1'b1;
    d.pinOut = 1'b0;
    d.pumpHigh = d.rfPumpGainSelect;
    if (d.autoActive) begin
      d.pumpHigh = 1'b1; // see [RQ6]
    end else if (d.fastlockTimeoutCode >= AUTO_MIN_CODE) begin
      d.pinOe = 1'b0; // see [RQ7]
      d.pumpHigh = 1'b0; // see [RQ7]
    end else begin
      case (d.fastlockTimeoutCode)
        CODE_TRISTATE: d.pinOe = 1'b0; // see [RQ2]
        CODE_MANUAL: d.pumpHigh = 1'b1; // see [RQ3]
        CODE_DRIVE_LOW: d.pinOut = 1'b0; // see [RQ4]
        CODE_DRIVE_HIGH: d.pinOut = 1'b1; // see [RQ5]
        default: d.pinOe = 1'b0;
      endcase
    end
    if (!resetn) begin
      d = CTRL_STATE_RESET;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign fastlockIndicatorPinOut = q.pinOut;
  assign fastlockIndicatorPinOe = q.pinOe;
  assign rfPumpOutputCurrentHigh = q.pumpHigh;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_low_codes_manual: assert property ( // see [RQ1]
    (q.fastlockTimeoutCode < AUTO_MIN_CODE) |-> !q.autoActive)
    else $error("automatic fastlock active with a low code");
  chk_code0_tristate: assert property ( // see [RQ2]
    (q.fastlockTimeoutCode == CODE_TRISTATE) |-> !q.pinOe && (q.pumpHigh == q.rfPumpGainSelect))
    else $error("code 0 pin or pump wrong");
  chk_code1_manual: assert property ( // see [RQ3]
    (q.fastlockTimeoutCode == CODE_MANUAL) |-> q.pinOe && !q.pinOut && q.pumpHigh)
    else $error("code 1 manual fastlock wrong");
  chk_code2_low: assert property ( // see [RQ4]
    (q.fastlockTimeoutCode == CODE_DRIVE_LOW)
      |-> q.pinOe && !q.pinOut && (q.pumpHigh == q.rfPumpGainSelect))
    else $error("code 2 pin or pump wrong");
  chk_code3_high: assert property ( // see [RQ5]
    (q.fastlockTimeoutCode == CODE_DRIVE_HIGH)
      |-> q.pinOe && q.pinOut && (q.pumpHigh == q.rfPumpGainSelect))
    else $error("code 3 pin or pump wrong");
  chk_auto_drive: assert property ( // see [RQ6]
    q.autoActive |-> q.pinOe && !q.pinOut && q.pumpHigh)
    else $error("automatic fastlock outputs wrong");
  chk_auto_expiry: assert property ( // see [RQ7]
    (pfdEvent && q.autoActive && !q.pendValid
      && ((q.eventCount + COUNT_STEP) == q.fastlockTimeoutCode))
      |=> !q.autoActive && !q.pinOe && !q.pumpHigh)
    else $error("fastlock period did not expire at the count");
  chk_latch_on_event: assert property ( // see [RQ8]
    !pfdEvent |=> $stable(q.fastlockTimeoutCode))
    else $error("code changed without an event");
  chk_latch_value: assert property ( // see [RQ10]
    (pfdEvent && q.pendValid) |=> (q.fastlockTimeoutCode == $past(pendCode)) && !q.pendValid)
    else $error("latched code differs from the written field");
  chk_restart_count: assert property ( // see [RQ11]
    (pfdEvent && q.pendValid && (pendCode >= AUTO_MIN_CODE))
      |=> q.autoActive && (q.eventCount == '0))
    else $error("fastlock period not restarted");
  chk_bresp_hold: assert property (
    (q.bvalid && !bready) |=> q.bvalid && $stable(q.bresp))
    else $error("write response dropped before acceptance");

  cov_auto_expire: cover property ($fell(q.autoActive) && (q.fastlockTimeoutCode >= AUTO_MIN_CODE));
  cov_manual: cover property (q.fastlockTimeoutCode == CODE_MANUAL);
  cov_drive_high: cover property (q.pinOe && q.pinOut);
  cov_slverr: cover property (q.bvalid && (q.bresp == RESP_SLVERR));
endmodule : rf_fastlock_timeout_control
`default_nettype wire

// [core/unused_placeholder_none.sv]
// Intentionally empty file slot is not used.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [sim/axi_host_model.sv]
// Register-bus host that writes control words and reads registers back.
`timescale 1ns/10ps
`default_nettype none
module axi_host_model
  import fastlock_pkg::*;
(
  input wire logic clock,
  output logic awvalid,
  input wire logic awready,
  output logic [ADDR_W-1:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      // Released payload is scrambled so a slave cannot lean on stale values.
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : write
  task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : read
  task automatic write_code(input logic [TOC_W-1:0] c);
    logic [1:0] r;
    write(TIMEOUT_WORD_OFFSET, 32'(c) << TOC_LSB, r);
  endtask : write_code
endmodule : axi_host_model
`default_nettype wire

// [sim/rf_fastlock_timeout_control_test.sv]
// Self-checking bench for the RF fastlock time-out controller.
`timescale 1ns/10ps
`default_nettype none
module rf_fastlock_timeout_control_test
  import fastlock_pkg::*;
;
  logic clock, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pfdEventPin, pinOut, pinOe, pumpHigh;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0;
  int total_checks = 0;
  rf_fastlock_timeout_control u_dut (.clock(clock), .resetn(resetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .pfdEventPin(pfdEventPin), .fastlockIndicatorPinOut(pinOut),
    .fastlockIndicatorPinOe(pinOe), .rfPumpOutputCurrentHigh(pumpHigh));
  axi_host_model u_host (.clock(clock), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // The pin is held past the filter depth on both levels so every pulse counts once.
  task automatic pfd_event;
    @(posedge clock) pfdEventPin <= 1'b1;
    repeat (4) @(posedge clock);
    pfdEventPin <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : pfd_event
  task automatic pins(input logic oe, input logic out, input logic pump);
    check(32'({pinOe, pinOe & pinOut, pumpHigh}), 32'({oe, out, pump}));
  endtask : pins
  task automatic test_reset;
    pins(1'b0, 1'b0, 1'b0);
    u_host.read(TIMEOUT_WORD_OFFSET, rd, resp);
    check(rd, 32'(TIMEOUT_WORD_RESET));
    u_host.read(4'hc, rd, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    // Unmapped and read-only writes must answer without touching any state.
    u_host.write(4'hc, 32'h00000000, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    u_host.write(STATUS_OFFSET, 32'hffffffff, resp);
    check(32'(resp), 32'(RESP_OKAY));
    u_host.read(STATUS_OFFSET, rd, resp);
    check(rd, 32'h00000000);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_codes;
    logic [2:0] prev, want;
    prev = 3'b000;
    for (int g = 0; g < 2; g++) begin
      u_host.write(PUMP_CONTROL_OFFSET, 32'(g), resp);
      prev[0] = (prev[2] && !prev[1] && want[0] && g == 0) ? 1'b1 : 1'(g);
      for (int c = 0; c < 4; c++) begin
        u_host.write_code(TOC_W'(c));
        pins(prev[2], prev[1], prev[0]);
        pfd_event();
        want = {c != 0, c == 3, (c == 1) ? 1'b1 : 1'(g)};
        pins(want[2], want[1], want[0]);
        prev = want;
      end
    end
    $display("test_codes done");
  endtask : test_codes
  task automatic test_auto;
    u_host.write(PUMP_CONTROL_OFFSET, 32'h0, resp);
    for (int k = 0; k < 2; k++) begin
      u_host.write_code(AUTO_MIN_CODE);
      pfd_event();
      pins(1'b1, 1'b0, 1'b1);
      repeat (3) pfd_event();
      pins(1'b1, 1'b0, 1'b1);
      pfd_event();
      pins(1'b0, 1'b0, 1'b0);
    end
    u_host.write_code(12'hfff);
    // The new word waits as pending while the old code stays in force.
    u_host.read(STATUS_OFFSET, rd, resp);
    check(32'(rd[STATUS_PEND_BIT]), 32'h00000001);
    check(32'(rd[STATUS_CODE_LSB +: TOC_W]), 32'(AUTO_MIN_CODE));
    pfd_event();
    pins(1'b1, 1'b0, 1'b1);
    u_host.read(STATUS_OFFSET, rd, resp);
    check(32'(rd[STATUS_CODE_LSB +: TOC_W]), 32'h00000fff);
    $display("test_auto done");
  endtask : test_auto
  initial begin
    resetn = 1'b0;
    pfdEventPin = 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    test_reset();
    test_codes();
    test_auto();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule : rf_fastlock_timeout_control_test
`default_nettype wire
